// ===== include/tlb_match_regs.svh
`ifndef TLB_MATCH_REGS_SVH
`define TLB_MATCH_REGS_SVH
// register byte offsets
`define TLBM_CTRL_OFF 12'h000
`define TLBM_STATUS_OFF 12'h004
// control register fields
`define TLBM_CTRL_IGN_NS_BIT 0
`define TLBM_CTRL_IGN_S_BIT 1
`define TLBM_CTRL_STAGE2_BIT 2
`define TLBM_CTRL_RST 3'h4
// status register fields
`define TLBM_STATUS_VALID_LSB 0
`define TLBM_STATUS_BUSY_BIT 8
// translation cache size
`define TLBM_ENTRIES 8
`endif

// ===== include/tlb_match_pkg.sv
package tlb_match_pkg;
   typedef logic [15:0] asid_t;
   typedef logic [15:0] vmid_t;
   typedef logic [19:0] page_t;
   typedef logic [2:0] idx_t;
   // translation_regime_tag values
   typedef enum logic [2:0] {
      RG_GUEST = 3'h0, RG_HYP = 3'h1, RG_HYP_HOST = 3'h2, RG_SECURE = 3'h3, RG_MONITOR = 3'h4
   } regime_e;
   // scope named by a broadcast invalidation
   typedef enum logic [2:0] {
      BS_GUEST = 3'h0, BS_SECURE = 3'h1, BS_LEGACY_SECURE = 3'h2, BS_HYP = 3'h3,
      BS_HYP_HOST = 3'h4, BS_MONITOR = 3'h5
   } bscope_e;
   typedef enum logic [1:0] {
      BC_INVAL_BY_ADDR = 2'h0, BC_INVAL_ADDR_ALL_ASID = 2'h1, BC_INVAL_BY_ASID = 2'h2,
      BC_INVAL_ALL = 2'h3
   } bcop_e;
   typedef enum logic [2:0] {
      CMD_GUEST_INVAL_ALL = 3'h0, CMD_GUEST_INVAL_BY_ASID = 3'h1,
      CMD_GUEST_INVAL_ADDR_ALL_ASID = 3'h2, CMD_GUEST_INVAL_BY_ADDR = 3'h3,
      CMD_MONITOR_INVAL_BY_ADDR = 3'h4, CMD_MONITOR_INVAL_ALL = 3'h5
   } cmdop_e;
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SCAN = 2'b01, ST_DONE = 2'b11} inv_state_e;
   typedef struct packed {
      logic valid;
      regime_e regime;
      logic stage2_only;
      logic not_global_flag;
      logic address_set_flag;
      asid_t asid;
      vmid_t vmid;
      page_t va;
      page_t pa;
   } entry_s;
endpackage

// ===== include/tlb_req_if.sv
`timescale 1ns/10ps
`default_nettype none
interface tlb_req_if
   import tlb_match_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn
);
   regime_e lkp_regime;
   asid_t lkp_asid;
   vmid_t lkp_vmid;
   page_t lkp_va;
   logic lkp_addr_set;
   logic inv_is_cmd;
   bcop_e inv_bc_op;
   cmdop_e inv_cmd_op;
   bscope_e inv_scope;
   logic inv_secure;
   asid_t inv_asid;
   vmid_t inv_vmid;
   page_t inv_va;
   logic stage2_present_flag;
   modport drv(output lkp_regime, lkp_asid, lkp_vmid, lkp_va, lkp_addr_set, inv_is_cmd, inv_bc_op,
      inv_cmd_op, inv_scope, inv_secure, inv_asid, inv_vmid, inv_va, stage2_present_flag);
   modport mat(input pclk, presetn, lkp_regime, lkp_asid, lkp_vmid, lkp_va, lkp_addr_set,
      inv_is_cmd, inv_bc_op, inv_cmd_op, inv_scope, inv_secure, inv_asid, inv_vmid, inv_va,
      stage2_present_flag);
endinterface
`default_nettype wire

// ===== rtl/tlb_entry_match.sv
`timescale 1ns/10ps
`default_nettype none
module tlb_entry_match
   import tlb_match_pkg::*;
(
   // shared request fields
   tlb_req_if.mat req,
   // stored entry
   input wire entry_s ent,
   // match results
   output logic lkp_hit,
   output logic inv_hit
);
   logic has_asid;
   logic skip_ok;
   logic vm_ok;
   logic rg_ok;
   logic bc_hit;
   logic cmd_hit;
   logic va_eq;
   logic asid_eq;

   // only these regimes carry an asid; the rest ignore asid and global flag
   assign has_asid = (ent.regime == RG_GUEST) || (ent.regime == RG_HYP_HOST) ||
      (ent.regime == RG_SECURE);
   assign va_eq = (ent.va == req.inv_va);
   assign asid_eq = (ent.asid == req.inv_asid);
   assign skip_ok = ent.address_set_flag && !ent.stage2_only;

   ////////////////////////////////////////////////////////////////////////////////
   // lookup match
   always_comb begin
      lkp_hit = ent.valid && (ent.regime == req.lkp_regime) && (ent.va == req.lkp_va);
      if (ent.regime == RG_GUEST && req.stage2_present_flag && ent.vmid != req.lkp_vmid) begin
         lkp_hit = 1'b0;
      end
      if (has_asid) begin
         if (ent.not_global_flag) begin
            if (ent.asid != req.lkp_asid) begin
               lkp_hit = 1'b0;
            end
         end else if (ent.address_set_flag != req.lkp_addr_set) begin
            lkp_hit = 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // invalidation match, broadcast and command
   always_comb begin
      if (ent.regime != RG_GUEST) begin
         vm_ok = 1'b1;
      end else if (req.stage2_present_flag) begin
         vm_ok = (ent.vmid == req.inv_vmid);
      end else begin
         vm_ok = req.inv_is_cmd || (req.inv_vmid == 16'h0000);
      end
      // legacy secure never reaches monitor, host mode never reaches plain hyp
      case (req.inv_scope)
         BS_GUEST: rg_ok = (ent.regime == RG_GUEST);
         BS_SECURE, BS_LEGACY_SECURE: rg_ok = (ent.regime == RG_SECURE);
         BS_HYP: rg_ok = (ent.regime == RG_HYP);
         BS_HYP_HOST: rg_ok = (ent.regime == RG_HYP_HOST);
         BS_MONITOR: rg_ok = (ent.regime == RG_MONITOR);
         default: rg_ok = 1'b0;
      endcase
      case (req.inv_bc_op)
         BC_INVAL_ALL: bc_hit = 1'b1;
         BC_INVAL_BY_ASID: bc_hit = has_asid && ent.not_global_flag && asid_eq && !skip_ok;
         BC_INVAL_BY_ADDR: begin
            bc_hit = va_eq && (!has_asid || !ent.not_global_flag || asid_eq) && !skip_ok;
         end
         BC_INVAL_ADDR_ALL_ASID: bc_hit = va_eq && !(skip_ok && ent.regime == RG_HYP);
         default: bc_hit = 1'b0;
      endcase
      // commands ignore the address-set flag entirely
      case (req.inv_cmd_op)
         CMD_GUEST_INVAL_ALL: cmd_hit = 1'b1;
         CMD_GUEST_INVAL_BY_ASID: cmd_hit = ent.not_global_flag && asid_eq;
         CMD_GUEST_INVAL_ADDR_ALL_ASID: cmd_hit = va_eq;
         CMD_GUEST_INVAL_BY_ADDR: cmd_hit = va_eq && (!ent.not_global_flag || asid_eq);
         CMD_MONITOR_INVAL_BY_ADDR: cmd_hit = va_eq && (ent.regime == RG_MONITOR);
         CMD_MONITOR_INVAL_ALL: cmd_hit = (ent.regime == RG_MONITOR);
         default: cmd_hit = 1'b0;
      endcase
      if (req.inv_cmd_op inside {CMD_MONITOR_INVAL_BY_ADDR, CMD_MONITOR_INVAL_ALL}) begin
         cmd_hit = cmd_hit && req.inv_secure;
      end else begin
         cmd_hit = cmd_hit && (ent.regime == (req.inv_secure ? RG_SECURE : RG_GUEST));
      end
      inv_hit = ent.valid && vm_ok && (req.inv_is_cmd ? cmd_hit : (bc_hit && rg_ok));
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks on the match relations
   property p_regime_iso;
      @(posedge req.pclk) disable iff (!req.presetn) lkp_hit |-> ent.regime == req.lkp_regime;
   endproperty
   a_regime_iso: assert property (p_regime_iso) else $error("cross regime hit");
   property p_global_set;
      @(posedge req.pclk) disable iff (!req.presetn)
         lkp_hit && has_asid && !ent.not_global_flag |-> ent.address_set_flag == req.lkp_addr_set;
   endproperty
   a_global_set: assert property (p_global_set) else $error("global address-set mismatch");
   property p_ng_asid;
      @(posedge req.pclk) disable iff (!req.presetn)
         lkp_hit && has_asid && ent.not_global_flag |-> ent.asid == req.lkp_asid;
   endproperty
   a_ng_asid: assert property (p_ng_asid) else $error("non-global asid mismatch");
   property p_asid_global;
      @(posedge req.pclk) disable iff (!req.presetn)
         !req.inv_is_cmd && req.inv_bc_op == BC_INVAL_BY_ASID && !ent.not_global_flag |-> !inv_hit;
   endproperty
   a_asid_global: assert property (p_asid_global) else $error("by-asid hit global");
   property p_host_hyp;
      @(posedge req.pclk) disable iff (!req.presetn)
         !req.inv_is_cmd && req.inv_scope == BS_HYP_HOST && ent.regime == RG_HYP |-> !inv_hit;
   endproperty
   a_host_hyp: assert property (p_host_hyp) else $error("host mode hit hyp");
   property p_all_shared;
      @(posedge req.pclk) disable iff (!req.presetn)
         !req.inv_is_cmd && req.inv_bc_op == BC_INVAL_ALL && ent.valid && rg_ok && vm_ok
         |-> inv_hit;
   endproperty
   a_all_shared: assert property (p_all_shared) else $error("invalidate-all missed");
   property p_cmd_any_set;
      @(posedge req.pclk) disable iff (!req.presetn)
         req.inv_is_cmd && req.inv_cmd_op == CMD_GUEST_INVAL_ALL && ent.valid && vm_ok &&
         ent.regime == (req.inv_secure ? RG_SECURE : RG_GUEST) |-> inv_hit;
   endproperty
   a_cmd_any_set: assert property (p_cmd_any_set) else $error("command skipped entry");
endmodule
`default_nettype wire

// ===== rtl/tlb_match_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "tlb_match_regs.svh"
module tlb_match_top
   import tlb_match_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // translation insertion
   input wire logic ins_valid,
   input wire regime_e ins_regime,
   input wire logic ins_stage2_only,
   input wire logic ins_not_global_flag,
   input wire logic ins_address_set_flag,
   input wire logic ins_desc_nonsecure,
   input wire asid_t ins_asid,
   input wire vmid_t ins_vmid,
   input wire page_t ins_va,
   input wire page_t ins_pa,
   output logic ins_ready,
   // lookup
   input wire logic lkp_valid,
   input wire regime_e lkp_regime,
   input wire logic lkp_address_set_flag,
   input wire asid_t lkp_asid,
   input wire vmid_t lkp_vmid,
   input wire page_t lkp_va,
   output logic lkp_done,
   output logic lkp_hit,
   output page_t lkp_pa,
   // broadcast invalidation
   input wire logic bc_valid,
   input wire bcop_e bc_op,
   input wire bscope_e bc_scope,
   input wire logic bc_secure,
   input wire asid_t bc_asid,
   input wire vmid_t bc_vmid,
   input wire page_t bc_va,
   output logic bc_done,
   // command invalidation
   input wire logic cmd_valid,
   input wire cmdop_e cmd_op,
   input wire logic cmd_secure,
   input wire asid_t cmd_asid,
   input wire vmid_t cmd_vmid,
   input wire page_t cmd_va,
   output logic cmd_done
);
   localparam int NENT = `TLBM_ENTRIES;

   logic [2:0] ctrl_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   inv_state_e state_ff;
   inv_state_e nxt_state;
   logic is_cmd_ff;
   logic ign_ff;
   bcop_e bc_op_ff;
   cmdop_e cmd_op_ff;
   bscope_e scope_ff;
   logic secure_ff;
   asid_t asid_ff;
   vmid_t vmid_ff;
   page_t va_ff;
   logic bc_done_ff;
   logic cmd_done_ff;
   logic ins_ready_ff;
   logic lkp_done_ff;
   logic lkp_hit_ff;
   page_t lkp_pa_ff;
   idx_t ins_ptr_ff;
   entry_s ent_ff [NENT];
   entry_s ins_ent;
   logic [NENT-1:0] lkp_vec;
   logic [NENT-1:0] inv_vec;
   logic [NENT-1:0] valid_vec;
   logic [NENT-1:0] kill_vec;
   logic take;
   logic ins_take;
   logic ins_asid_tag;
   page_t hit_pa;

   tlb_req_if req_if (.pclk(pclk), .presetn(presetn));

   ////////////////////////////////////////////////////////////////////////////////
   // apb slave, zero wait states: pready rises in the access phase
   wire logic apb_setup = psel && !penable;
   wire logic apb_write = psel && penable && pready_ff && pwrite;
   wire logic hit_ctrl = (paddr == `TLBM_CTRL_OFF);
   wire logic hit_stat = (paddr == `TLBM_STATUS_OFF);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end else begin
         pready_ff <= apb_setup;
         pslverr_ff <= apb_setup && !hit_ctrl && !hit_stat;
         prdata_ff <= 32'h0000_0000;
         if (apb_setup && !pwrite && hit_ctrl) begin
            prdata_ff <= {29'h0000_0000, ctrl_ff};
         end else if (apb_setup && !pwrite && hit_stat) begin
            prdata_ff <= {23'h00_0000, state_ff != ST_IDLE, valid_vec};
         end
      end
   end

   // control bits steer broadcast filtering and vmid handling
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= `TLBM_CTRL_RST;
      end else if (apb_write && hit_ctrl) begin
         ctrl_ff <= pwdata[2:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // invalidation sequencer; broadcasts win over commands when both wait
   assign take = (state_ff == ST_IDLE) && (bc_valid || cmd_valid);

   always_comb begin
      case (state_ff)
         ST_IDLE: nxt_state = take ? ST_SCAN : ST_IDLE;
         ST_SCAN: nxt_state = ST_DONE;
         ST_DONE: nxt_state = ST_IDLE;
         default: nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // request held in DONE too, so the done cycle still sees what it removed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         is_cmd_ff <= 1'b0;
         ign_ff <= 1'b0;
         bc_op_ff <= BC_INVAL_BY_ADDR;
         cmd_op_ff <= CMD_GUEST_INVAL_ALL;
         scope_ff <= BS_GUEST;
         secure_ff <= 1'b0;
         asid_ff <= 16'h0000;
         vmid_ff <= 16'h0000;
         va_ff <= 20'h0_0000;
      end else if (take) begin
         is_cmd_ff <= !bc_valid;
         ign_ff <= bc_valid && (bc_secure ? ctrl_ff[`TLBM_CTRL_IGN_S_BIT] :
            ctrl_ff[`TLBM_CTRL_IGN_NS_BIT]);
         bc_op_ff <= bc_op;
         cmd_op_ff <= cmd_op;
         scope_ff <= bc_scope;
         secure_ff <= bc_valid ? bc_secure : cmd_secure;
         asid_ff <= bc_valid ? bc_asid : cmd_asid;
         vmid_ff <= bc_valid ? bc_vmid : cmd_vmid;
         va_ff <= bc_valid ? bc_va : cmd_va;
      end
   end

   // completion only after the scan edge, which has cleared every match unless the broadcast was ignored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bc_done_ff <= 1'b0;
         cmd_done_ff <= 1'b0;
      end else begin
         bc_done_ff <= (state_ff == ST_SCAN) && !is_cmd_ff;
         cmd_done_ff <= (state_ff == ST_SCAN) && is_cmd_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // shared request fields for the per-entry matchers
   assign req_if.lkp_regime = lkp_regime;
   assign req_if.lkp_asid = lkp_asid;
   assign req_if.lkp_vmid = lkp_vmid;
   assign req_if.lkp_va = lkp_va;
   assign req_if.lkp_addr_set = lkp_address_set_flag;
   assign req_if.inv_is_cmd = is_cmd_ff;
   assign req_if.inv_bc_op = bc_op_ff;
   assign req_if.inv_cmd_op = cmd_op_ff;
   assign req_if.inv_scope = scope_ff;
   assign req_if.inv_secure = secure_ff;
   assign req_if.inv_asid = asid_ff;
   assign req_if.inv_vmid = vmid_ff;
   assign req_if.inv_va = va_ff;
   assign req_if.stage2_present_flag = ctrl_ff[`TLBM_CTRL_STAGE2_BIT];

   ////////////////////////////////////////////////////////////////////////////////
   // insertion: tags are normalised here so matching stays simple
   assign ins_take = ins_valid && ins_ready_ff;
   assign ins_asid_tag = (ins_regime == RG_GUEST) || (ins_regime == RG_HYP_HOST) ||
      (ins_regime == RG_SECURE);

   always_comb begin
      ins_ent = '0;
      ins_ent.valid = 1'b1;
      ins_ent.regime = ins_regime;
      ins_ent.stage2_only = ins_stage2_only && (ins_regime == RG_GUEST);
      // global flag has no meaning without asids; non-secure tables in the secure regime force non-global
      ins_ent.not_global_flag = ins_asid_tag && !ins_ent.stage2_only && (ins_not_global_flag ||
         (ins_regime == RG_SECURE && ins_desc_nonsecure));
      ins_ent.address_set_flag = ins_address_set_flag && !ins_ent.stage2_only;
      ins_ent.asid = ins_ent.not_global_flag ? ins_asid : 16'h0000;
      ins_ent.vmid = (ins_regime == RG_GUEST && ctrl_ff[`TLBM_CTRL_STAGE2_BIT]) ? ins_vmid :
         16'h0000;
      ins_ent.va = ins_va;
      ins_ent.pa = ins_pa;
   end

   // inserts wait out scan and done so no fresh entry dodges a running removal
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ins_ready_ff <= 1'b1;
         ins_ptr_ff <= 3'h0;
      end else begin
         ins_ready_ff <= (nxt_state == ST_IDLE);
         if (ins_take) begin
            ins_ptr_ff <= ins_ptr_ff + 3'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // entry storage with one matcher per entry; plain round-robin replacement
   assign kill_vec = (state_ff == ST_SCAN && !ign_ff) ? inv_vec : '0;

   generate
      for (genvar gi = 0; gi < NENT; gi++) begin : g_ent
         tlb_entry_match u_match (
            .req(req_if),
            .ent(ent_ff[gi]),
            .lkp_hit(lkp_vec[gi]),
            .inv_hit(inv_vec[gi])
         );
         assign valid_vec[gi] = ent_ff[gi].valid;
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ent_ff[gi] <= '0;
            end else if (kill_vec[gi]) begin
               ent_ff[gi].valid <= 1'b0;
            end else if (ins_take && ins_ptr_ff == idx_t'(gi)) begin
               ent_ff[gi] <= ins_ent;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // lookup result one cycle later; entries being killed this cycle never hit
   always_comb begin
      hit_pa = 20'h0_0000;
      for (int i = NENT - 1; i >= 0; i--) begin
         if (lkp_vec[i] && !kill_vec[i]) begin
            hit_pa = ent_ff[i].pa;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lkp_done_ff <= 1'b0;
         lkp_hit_ff <= 1'b0;
         lkp_pa_ff <= 20'h0_0000;
      end else begin
         lkp_done_ff <= lkp_valid;
         lkp_hit_ff <= lkp_valid && |(lkp_vec & ~kill_vec);
         lkp_pa_ff <= lkp_valid ? hit_pa : 20'h0_0000;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign ins_ready = ins_ready_ff;
   assign lkp_done = lkp_done_ff;
   assign lkp_hit = lkp_hit_ff;
   assign lkp_pa = lkp_pa_ff;
   assign bc_done = bc_done_ff;
   assign cmd_done = cmd_done_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // checks and covers
   property p_done_clean;
      @(posedge pclk) disable iff (!presetn) state_ff == ST_DONE && !ign_ff |-> inv_vec == '0;
   endproperty
   a_done_clean: assert property (p_done_clean) else $error("match left after scan");
   property p_done_time;
      @(posedge pclk) disable iff (!presetn) take |=> ##1 (bc_done_ff || cmd_done_ff);
   endproperty
   a_done_time: assert property (p_done_time) else $error("done not two cycles on");
   property p_ignore;
      @(posedge pclk) disable iff (!presetn)
         state_ff == ST_SCAN && ign_ff |=> valid_vec == $past(valid_vec);
   endproperty
   a_ignore: assert property (p_ignore) else $error("ignored broadcast removed entry");
   property p_secure_ng;
      @(posedge pclk) disable iff (!presetn)
         ins_take && ins_regime == RG_SECURE && ins_desc_nonsecure |=>
         ent_ff[$past(ins_ptr_ff)].not_global_flag;
   endproperty
   a_secure_ng: assert property (p_secure_ng) else $error("secure entry left global");
   c_bc_done: cover property (@(posedge pclk) disable iff (!presetn) bc_done_ff && !ign_ff);
   c_cmd_done: cover property (@(posedge pclk) disable iff (!presetn) cmd_done_ff);
   c_lkp_hit: cover property (@(posedge pclk) disable iff (!presetn) lkp_hit_ff);
   c_ignored: cover property (@(posedge pclk) disable iff (!presetn) bc_done_ff && ign_ff);
endmodule
`default_nettype wire

// ===== verification/bcast_src.sv
`timescale 1ns/10ps
`default_nettype none
module bcast_src
   import tlb_match_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // order from the bench
   input wire logic go,
   input wire bcop_e op,
   input wire bscope_e scope,
   input wire logic sec,
   input wire asid_t asid,
   input wire page_t va,
   // broadcast toward the block
   output logic bc_valid,
   output bcop_e bc_op,
   output bscope_e bc_scope,
   output logic bc_secure,
   output asid_t bc_asid,
   output vmid_t bc_vmid,
   output page_t bc_va,
   input wire logic bc_done
);
   ////////////////////////////////////////////////////////////////////////////////
   // hold the message until done; when idle asid, vmid and va toggle so stale data never matches
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bc_valid <= 1'b0;
         bc_op <= BC_INVAL_ALL;
         bc_scope <= BS_GUEST;
         bc_secure <= 1'b0;
         bc_asid <= 16'h0000;
         bc_vmid <= 16'h0000;
         bc_va <= 20'h00000;
      end else if (bc_valid) begin
         bc_valid <= !bc_done;
      end else if (go) begin
         bc_valid <= 1'b1;
         bc_op <= op;
         bc_scope <= scope;
         bc_secure <= sec;
         bc_asid <= asid;
         bc_vmid <= 16'h0000;
         bc_va <= va;
      end else begin
         bc_asid <= ~bc_asid;
         bc_vmid <= ~bc_vmid;
         bc_va <= ~bc_va;
      end
   end
endmodule
`default_nettype wire

// ===== verification/tlb_tag_match_and_broadcast_inval_bench.sv
`timescale 1ns/10ps
`default_nettype none
module tlb_tag_match_and_broadcast_inval_bench
   import tlb_match_pkg::*;
;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, ins_valid = 1'b0, ins_loc = 1'b0, ins_as = 1'b0, ins_nsd = 1'b0, ins_ready;
   regime_e ins_rg = RG_GUEST, lkp_rg = RG_GUEST;
   asid_t ins_asid = '0, lkp_asid = '0, cmd_asid = '0, b_asid = '0, a, bc_asid;
   page_t ins_va = '0, lkp_va = '0, cmd_va = '0, b_va = '0, v, bc_va, lkp_pa;
   logic lkp_valid = 1'b0, lkp_as = 1'b0, lkp_done, lkp_hit, go = 1'b0, b_sec = 1'b0;
   logic bc_valid, bc_secure, bc_done, cmd_valid = 1'b0, cmd_sec = 1'b0, cmd_done;
   bcop_e b_op = BC_INVAL_ALL, bc_op;
   bscope_e b_sc = BS_GUEST, bc_scope;
   vmid_t bc_vmid;
   cmdop_e cmd_op = CMD_GUEST_INVAL_ALL;
   logic [32:0] q_hit[$], q_rd[$];
   int checked = 0, failures = 0, cyc = 0;
   always #2.5 pclk = ~pclk;
   // stage 2 only entries are not exercised; vmid is 0 in every request the block takes
   tlb_match_top i_tlb_match_top(.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ins_valid(ins_valid), .ins_regime(ins_rg),
      .ins_stage2_only(1'b0), .ins_not_global_flag(ins_loc), .ins_address_set_flag(ins_as),
      .ins_desc_nonsecure(ins_nsd), .ins_asid(ins_asid), .ins_vmid(16'h0000), .ins_va(ins_va),
      .ins_pa(ins_va), .ins_ready(ins_ready), .lkp_valid(lkp_valid), .lkp_regime(lkp_rg),
      .lkp_address_set_flag(lkp_as), .lkp_asid(lkp_asid), .lkp_vmid(16'h0000),
      .lkp_va(lkp_va), .lkp_done(lkp_done), .lkp_hit(lkp_hit), .lkp_pa(lkp_pa),
      .bc_valid(bc_valid), .bc_op(bc_op), .bc_scope(bc_scope), .bc_secure(bc_secure),
      .bc_asid(bc_asid), .bc_vmid(bc_vmid), .bc_va(bc_va), .bc_done(bc_done),
      .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_secure(cmd_sec), .cmd_asid(cmd_asid),
      .cmd_vmid(16'h0000), .cmd_va(cmd_va), .cmd_done(cmd_done));
   bcast_src i_bcast_src(.pclk(pclk), .presetn(presetn), .go(go), .op(b_op), .scope(b_sc),
      .sec(b_sec), .asid(b_asid), .va(b_va), .bc_valid(bc_valid), .bc_op(bc_op),
      .bc_scope(bc_scope), .bc_secure(bc_secure), .bc_asid(bc_asid), .bc_vmid(bc_vmid),
      .bc_va(bc_va), .bc_done(bc_done));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string s, input logic [32:0] e, input logic [32:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", s, e, g);
      end
   endtask
   // one apb transfer; an extra edge keeps psel from being driven twice in one step
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d,
      input logic [32:0] e);
      if (!w) q_rd.push_back(e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic ins(input regime_e r, input logic loc, input logic s);
      ins_valid <= 1'b1;
      ins_rg <= r;
      ins_loc <= loc;
      ins_as <= s;
      ins_asid <= a;
      ins_va <= v;
      do @(posedge pclk); while (ins_ready !== 1'b1);
      ins_valid <= 1'b0;
   endtask
   task automatic lk(input regime_e r, input logic s, input asid_t x, input logic e);
      q_hit.push_back({12'h000, e ? v : 20'h0_0000, e});
      lkp_valid <= 1'b1;
      lkp_rg <= r;
      lkp_as <= s;
      lkp_asid <= x;
      lkp_va <= v;
      @(posedge pclk);
      lkp_valid <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic bcast(input bcop_e o, input bscope_e sc, input logic s);
      go <= 1'b1;
      b_op <= o;
      b_sc <= sc;
      b_sec <= s;
      b_asid <= a;
      b_va <= v;
      @(posedge pclk);
      go <= 1'b0;
      do @(posedge pclk); while (bc_done !== 1'b1);
   endtask
   task automatic cmd(input cmdop_e o, input logic s);
      cmd_valid <= 1'b1;
      cmd_op <= o;
      cmd_sec <= s;
      cmd_asid <= a;
      cmd_va <= v;
      do @(posedge pclk); while (cmd_done !== 1'b1);
      cmd_valid <= 1'b0;
   endtask
   // results are matched against the oldest note left by the drivers
   always @(posedge pclk) begin
      if (lkp_done === 1'b1) chk("lkp_hit_pa", q_hit.pop_front(), {12'h000, lkp_pa, lkp_hit});
      if (psel && penable && !pwrite && pready === 1'b1) begin
         chk("prdata", q_rd.pop_front(), {pslverr, prdata});
      end
      cyc++;
      if (cyc == 3000) begin
         failures++;
         results();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      a = asid_t'($urandom(32'hE032));
      v = page_t'($urandom());
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0, 33'h0_0000_0004);
      apb(1'b0, 12'h010, 32'h0, 33'h1_0000_0000);
      ins(RG_GUEST, 1'b1, 1'b1);
      lk(RG_GUEST, 1'b0, a, 1'b1);
      lk(RG_HYP, 1'b1, a, 1'b0);
      bcast(BC_INVAL_ADDR_ALL_ASID, BS_GUEST, 1'b0);
      lk(RG_GUEST, 1'b1, a, 1'b0);
      ins(RG_GUEST, 1'b0, 1'b0);
      lk(RG_GUEST, 1'b0, a + 16'h0001, 1'b1);
      lk(RG_GUEST, 1'b1, a, 1'b0);
      cmd(CMD_GUEST_INVAL_ALL, 1'b0);
      lk(RG_GUEST, 1'b0, a, 1'b0);
      apb(1'b1, 12'h000, 32'h5, 33'h0);
      apb(1'b0, 12'h000, 32'h0, 33'h0_0000_0005);
      ins(RG_GUEST, 1'b1, 1'b0);
      bcast(BC_INVAL_ALL, BS_GUEST, 1'b0);
      lk(RG_GUEST, 1'b0, a, 1'b1);
      apb(1'b1, 12'h000, 32'h4, 33'h0);
      bcast(BC_INVAL_BY_ASID, BS_GUEST, 1'b0);
      lk(RG_GUEST, 1'b0, a, 1'b0);
      for (int i = 0; i < 4; i++) begin
         ins(RG_SECURE, 1'b1, 1'b0);
         bcast(bcop_e'(i), BS_SECURE, 1'b1);
         lk(RG_SECURE, 1'b0, a, 1'b0);
      end
      ins(RG_SECURE, 1'b1, 1'b1);
      bcast(BC_INVAL_ADDR_ALL_ASID, BS_LEGACY_SECURE, 1'b1);
      lk(RG_SECURE, 1'b1, a, 1'b0);
      ins(RG_SECURE, 1'b1, 1'b1);
      cmd(CMD_GUEST_INVAL_BY_ADDR, 1'b1);
      lk(RG_SECURE, 1'b1, a, 1'b0);
      ins(RG_HYP, 1'b0, 1'b1);
      bcast(BC_INVAL_ALL, BS_HYP, 1'b0);
      lk(RG_HYP, 1'b1, a, 1'b0);
      ins(RG_MONITOR, 1'b0, 1'b1);
      lk(RG_MONITOR, 1'b1, a + 16'h0002, 1'b1);
      bcast(BC_INVAL_ALL, BS_MONITOR, 1'b1);
      lk(RG_MONITOR, 1'b1, a, 1'b0);
      ins_nsd <= 1'b1;
      ins(RG_SECURE, 1'b0, 1'b0);
      ins_nsd <= 1'b0;
      lk(RG_SECURE, 1'b0, a + 16'h0001, 1'b0);
      apb(1'b0, 12'h004, 32'h0, 33'h0_0000_0008);
      results();
   end
endmodule
`default_nettype wire
